/* rtl/lcb_pattern.sv */
// one pattern generator: delay once, then ramp up, hold high, ramp down, hold low, repeat from ramp up
// assumes a one-cycle tick enable from the top-level divider
`timescale 1ns/1ps
module lcb_pattern (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // control
   input wire logic i_tick,
   input wire logic i_en,
   input wire lcb_pkg::lcb_pat_cfg_s i_cfg,
   // result
   output logic [7:0] o_level
);
   import lcb_pkg::*;
   lcb_pat_state_e state;
   logic [7:0] cnt;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !i_en) begin
         state <= P_IDLE;
         cnt <= 8'h00;
         o_level <= 8'h00;
      end else begin
         case (state)
            P_IDLE: begin
               state <= P_DELAY;
               cnt <= 8'h00;
               o_level <= i_cfg.low;
            end
            P_DELAY: if (i_tick) begin
               if (cnt >= i_cfg.delay) begin
                  state <= P_RISE;
                  cnt <= 8'h00;
               end else cnt <= cnt + 8'h01;
            end
            P_RISE: if (i_tick) begin
               if (o_level >= i_cfg.high) begin
                  state <= P_HIGH;
                  cnt <= 8'h00;
               end else if (cnt >= i_cfg.rise) begin
                  o_level <= o_level + 8'h01;
                  cnt <= 8'h00;
               end else cnt <= cnt + 8'h01;
            end
            P_HIGH: if (i_tick) begin
               if (cnt >= i_cfg.thigh) begin
                  state <= P_FALL;
                  cnt <= 8'h00;
               end else cnt <= cnt + 8'h01;
            end
            P_FALL: if (i_tick) begin
               if (o_level <= i_cfg.low) begin
                  state <= P_LOW;
                  cnt <= 8'h00;
               end else if (cnt >= i_cfg.fall) begin
                  o_level <= o_level - 8'h01;
                  cnt <= 8'h00;
               end else cnt <= cnt + 8'h01;
            end
            P_LOW: if (i_tick) begin
               if (cnt >= i_cfg.tlow) begin
                  state <= P_RISE;
                  cnt <= 8'h00;
               end else cnt <= cnt + 8'h01;
            end
            default: state <= P_IDLE;
         endcase
      end
   end

   property p_off_is_dark;
      @(posedge i_mclk) disable iff (i_sys_rst) !i_en |=> o_level == 8'h00;
   endproperty
   a_off_is_dark: assert property (p_off_is_dark) else $error("pattern not dark when off");

   property p_high_hold;
      @(posedge i_mclk) disable iff (i_sys_rst || !i_en)
         (state == P_RISE && i_tick && o_level >= i_cfg.high) |=> state == P_HIGH;
   endproperty
   a_high_hold: assert property (p_high_hold) else $error("pattern missed high phase");
endmodule

/* rtl/lcb_pkg.sv */
// shared constants and types of the led control bank mapper
// assumes one 250 MHz clock and registers reached over the two-wire target port
package lcb_pkg;
   localparam int CLK_PERIOD_NS = 4;
   // two-wire target address, arbitrary value
   localparam logic [6:0] DEV_ADDR = 7'h2a;
   localparam int REG_N = 128;
   localparam logic [7:0] REG_RESET = 8'h00;
   // register offsets
   localparam int OFS_STATUS = 'h01;
   localparam int OFS_SINK_CFG_ONE = 'h10;
   localparam int OFS_LV_CFG_LO = 'h11;
   localparam int OFS_LV_CFG_HI = 'h12;
   localparam int OFS_PWM_ASSIGN = 'h14;
   localparam int OFS_MAP_ASSIGN_LO = 'h15;
   localparam int OFS_MAP_ASSIGN_HI = 'h16;
   localparam int OFS_LINEAR_SEL = 'h1a;
   localparam int OFS_BRIGHT_BASE = 'h20;
   localparam int OFS_PAT_ENABLE = 'h28;
   localparam int OFS_ZONE_BND_BASE = 'h30;
   localparam int OFS_ZONE_TGT_BASE = 'h34;
   localparam int OFS_PAT_BASE = 'h50;
   localparam int PAT_STRIDE = 8;
   // pattern setting positions inside one generator's block
   localparam int PAT_RISE = 0;
   localparam int PAT_FALL = 1;
   localparam int PAT_DELAY = 2;
   localparam int PAT_HIGH = 3;
   localparam int PAT_LOW = 4;
   localparam int PAT_THIGH = 5;
   localparam int PAT_TLOW = 6;
   // geometry
   localparam int N_BANK = 6;
   localparam int N_HV_BANK = 2;
   localparam int N_LV_BANK = 4;
   localparam int N_LV_SINK = 5;
   localparam int N_ZONE = 5;
   localparam int N_MAPPER = 3;
   // timing
   localparam int PAT_TICK_NS = 1000;
   localparam int PAT_TICK_CYC = (PAT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWM_SAMPLE_NS = 40;
   localparam int PWM_SAMPLE_CYC = (PWM_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] PWM_WIN_LAST = 8'hfe;

   typedef struct packed {
      logic [7:0] rise;
      logic [7:0] fall;
      logic [7:0] delay;
      logic [7:0] high;
      logic [7:0] low;
      logic [7:0] thigh;
      logic [7:0] tlow;
   } lcb_pat_cfg_s;

   typedef enum {P_IDLE, P_DELAY, P_RISE, P_HIGH, P_FALL, P_LOW} lcb_pat_state_e;
   typedef enum {S_IDLE, S_ADDR, S_ACK, S_WR, S_RD, S_RACK} lcb_bus_state_e;
endpackage

/* rtl/lcb_top.sv */
// control logic of a backlight and indicator led driver with bank mapping
// assumes pins synchronous to i_mclk; analog sensing arrives as digital codes
//
// How it works
// - sinks never hold their own level; each copies its assigned bank's current.
// - high-voltage sinks pick bank A or B from bits 1:0 at 0x10.
// - four low-voltage banks; each of five low sinks picks any one.
// - four pattern generators, one per low-voltage bank, programmed independently.
// - each generator has rise, fall, delay, high, low, high time, low time.
// - ambient code is classed into five zones, each with its target current.
// - three mappers of zone targets, each assignable to any bank.
// - banks given the pwm input scale their current by measured duty.
// - enable pin low holds shutdown and returns every register to default.
// - at hot threshold boost, pump, sinks go off until cool threshold.
// - host reads and writes all configuration over the two-wire target port.
// - each bank selects exponential or linear code-to-current mapping.
`timescale 1ns/1ps
module lcb_top (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // device pins
   input wire logic i_hardware_enable_pin,
   input wire logic i_pwm_in,
   // two-wire host port
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // ambient light converter and die temperature comparators
   input wire logic [7:0] i_als_code,
   input wire logic i_als_valid,
   input wire logic i_temp_hot,
   input wire logic i_temp_cool,
   // power stage
   output logic o_boost_en,
   output logic o_pump_en,
   output logic [7:0] o_high_voltage_sink_one,
   output logic [7:0] o_high_voltage_sink_two,
   output logic [lcb_pkg::N_LV_SINK-1:0][7:0] o_lv_sink
);
   import lcb_pkg::*;

   function automatic logic [7:0] scale(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = 16'(a) * 16'(b) + 16'(a);
      return p[15:8];
   endfunction

   logic [7:0] regs [REG_N];
   logic therm_off, shut, pat_tick, pwm_tick, wr_stb;
   logic [7:0] pat_div, pwm_div, pwm_win, pwm_hi, duty, rd_val;
   logic [2:0] zone, next_zone;
   logic [7:0] bank_code [N_BANK];
   logic [7:0] pat_level [N_LV_BANK];
   logic [7:0] shreg, rd_sh;
   logic [6:0] ptr;
   logic [15:0] lv_w;
   logic [3:0] bitcnt;
   logic scl_q, sda_q, rw, first;
   lcb_bus_state_e bst;

   assign shut = !i_hardware_enable_pin || therm_off;
   assign o_sda = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // dividers for pattern steps and pwm sampling
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || pat_div == 8'(PAT_TICK_CYC - 1)) pat_div <= 8'h00;
      else pat_div <= pat_div + 8'h01;
   end
   assign pat_tick = pat_div == 8'(PAT_TICK_CYC - 1);

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || pwm_div == 8'(PWM_SAMPLE_CYC - 1)) pwm_div <= 8'h00;
      else pwm_div <= pwm_div + 8'h01;
   end
   assign pwm_tick = pwm_div == 8'(PWM_SAMPLE_CYC - 1);

   // duty measured as high samples out of 255
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pwm_win <= 8'h00;
         pwm_hi <= 8'h00;
         duty <= 8'h00;
      end else if (pwm_tick) begin
         if (pwm_win == PWM_WIN_LAST) begin
            duty <= pwm_hi + 8'(i_pwm_in);
            pwm_hi <= 8'h00;
            pwm_win <= 8'h00;
         end else begin
            pwm_hi <= pwm_hi + 8'(i_pwm_in);
            pwm_win <= pwm_win + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // thermal shutdown with hysteresis
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) therm_off <= 1'b0;
      else if (i_temp_hot) therm_off <= 1'b1;
      else if (i_temp_cool) therm_off <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-wire target: pointer byte first, then data; auto-increment
   always_ff @(posedge i_mclk) begin
      scl_q <= i_scl;
      sda_q <= i_sda;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !i_hardware_enable_pin) begin
         bst <= S_IDLE;
         o_sda_oe <= 1'b0;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         rd_sh <= 8'h00;
         ptr <= 7'h00;
         rw <= 1'b0;
         first <= 1'b0;
      end else if (scl_q && i_scl && sda_q && !i_sda) begin
         bst <= S_ADDR;
         bitcnt <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (scl_q && i_scl && !sda_q && i_sda) begin
         bst <= S_IDLE;
         o_sda_oe <= 1'b0;
      end else begin
         case (bst)
            S_ADDR, S_WR: begin
               if (i_scl && !scl_q) begin
                  shreg <= {shreg[6:0], i_sda};
                  bitcnt <= bitcnt + 4'h1;
               end else if (!i_scl && scl_q && bitcnt == 4'h8) begin
                  bitcnt <= 4'h0;
                  if (bst == S_ADDR) begin
                     if (shreg[7:1] == DEV_ADDR) begin
                        o_sda_oe <= 1'b1;
                        rw <= shreg[0];
                        first <= 1'b1;
                        bst <= S_ACK;
                     end else bst <= S_IDLE;
                  end else begin
                     o_sda_oe <= 1'b1;
                     first <= 1'b0;
                     if (first) ptr <= shreg[6:0];
                     else ptr <= ptr + 7'h01;
                     bst <= S_ACK;
                  end
               end
            end
            S_ACK: if (!i_scl && scl_q) begin
               if (rw) begin
                  rd_sh <= rd_val;
                  o_sda_oe <= !rd_val[7];
                  bitcnt <= 4'h0;
                  bst <= S_RD;
               end else begin
                  o_sda_oe <= 1'b0;
                  bst <= S_WR;
               end
            end
            S_RD: begin
               if (i_scl && !scl_q) bitcnt <= bitcnt + 4'h1;
               else if (!i_scl && scl_q) begin
                  if (bitcnt == 4'h8) begin
                     o_sda_oe <= 1'b0;
                     ptr <= ptr + 7'h01;
                     bst <= S_RACK;
                  end else o_sda_oe <= !rd_sh[3'(4'h7 - bitcnt)];
               end
            end
            S_RACK: begin
               if (i_scl && !scl_q && i_sda) bst <= S_IDLE;
               else if (!i_scl && scl_q) begin
                  rd_sh <= rd_val;
                  o_sda_oe <= !rd_val[7];
                  bitcnt <= 4'h0;
                  bst <= S_RD;
               end
            end
            default: o_sda_oe <= 1'b0;
         endcase
      end
   end

   assign wr_stb = bst == S_WR && !i_scl && scl_q && bitcnt == 4'h8 && !first;
   assign rd_val = (int'(ptr) == OFS_STATUS) ? {4'h0, zone, therm_off} : regs[ptr];

   ////////////////////////////////////////////////////////////////////////////
   // register file, cleared while the enable pin is low
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !i_hardware_enable_pin) begin
         for (int i = 0; i < REG_N; i++) regs[i] <= REG_RESET;
      end else if (wr_stb && int'(ptr) != OFS_STATUS) begin
         regs[ptr] <= shreg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ambient zone classification against four ascending boundaries
   always_comb begin
      next_zone = 3'd0;
      for (int i = 0; i < N_ZONE - 1; i++) begin
         if (i_als_code > regs[OFS_ZONE_BND_BASE + i]) next_zone = next_zone + 3'd1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || !i_hardware_enable_pin) zone <= 3'd0;
      else if (i_als_valid) zone <= next_zone;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pattern generators on the low-voltage banks
   for (genvar g = 0; g < N_LV_BANK; g++) begin : g_pat
      lcb_pattern u_pat (
         .i_mclk(i_mclk),
         .i_sys_rst(i_sys_rst),
         .i_tick(pat_tick),
         .i_en(regs[OFS_PAT_ENABLE][g] && i_hardware_enable_pin),
         .i_cfg(lcb_pat_cfg_s'{rise: regs[OFS_PAT_BASE + PAT_STRIDE*g + PAT_RISE],
                  fall: regs[OFS_PAT_BASE + PAT_STRIDE*g + PAT_FALL],
                  delay: regs[OFS_PAT_BASE + PAT_STRIDE*g + PAT_DELAY],
                  high: regs[OFS_PAT_BASE + PAT_STRIDE*g + PAT_HIGH],
                  low: regs[OFS_PAT_BASE + PAT_STRIDE*g + PAT_LOW],
                  thigh: regs[OFS_PAT_BASE + PAT_STRIDE*g + PAT_THIGH],
                  tlow: regs[OFS_PAT_BASE + PAT_STRIDE*g + PAT_TLOW]}),
         .o_level(pat_level[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // bank current: source, then mapping curve, then pwm scaling
   always_comb begin
      logic [15:0] map_w;
      logic [1:0] m;
      logic [7:0] c;
      map_w = {regs[OFS_MAP_ASSIGN_HI], regs[OFS_MAP_ASSIGN_LO]};
      m = 2'd0;
      c = 8'h00;
      for (int b = 0; b < N_BANK; b++) begin
         m = map_w[2*b +: 2];
         if (m != 2'd0) c = regs[OFS_ZONE_TGT_BASE + N_ZONE*(int'(m) - 1) + int'(zone)];
         else if (b >= N_HV_BANK && regs[OFS_PAT_ENABLE][b - N_HV_BANK])
            c = pat_level[b - N_HV_BANK];
         else c = regs[OFS_BRIGHT_BASE + b];
         if (!regs[OFS_LINEAR_SEL][b]) c = scale(c, c);
         if (regs[OFS_PWM_ASSIGN][b]) c = scale(c, duty);
         bank_code[b] = c;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sinks copy their bank each cycle; dark in shutdown
   assign lv_w = {regs[OFS_LV_CFG_HI], regs[OFS_LV_CFG_LO]};
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || shut) begin
         o_high_voltage_sink_one <= 8'h00;
         o_high_voltage_sink_two <= 8'h00;
         o_lv_sink <= '0;
      end else begin
         o_high_voltage_sink_one <= bank_code[regs[OFS_SINK_CFG_ONE][0]];
         o_high_voltage_sink_two <= bank_code[regs[OFS_SINK_CFG_ONE][1]];
         for (int s = 0; s < N_LV_SINK; s++)
            o_lv_sink[s] <= bank_code[N_HV_BANK + int'(lv_w[2*s +: 2])];
      end
   end

   always_ff @(posedge i_mclk) begin
      o_boost_en <= !(i_sys_rst || shut);
      o_pump_en <= !(i_sys_rst || shut);
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_hot_trips;
      @(posedge i_mclk) disable iff (i_sys_rst) i_temp_hot |=> therm_off ##1 !o_boost_en;
   endproperty
   a_hot_trips: assert property (p_hot_trips) else $error("hot die did not shut down");

   property p_hysteresis;
      @(posedge i_mclk) disable iff (i_sys_rst) therm_off && !i_temp_cool |=> therm_off;
   endproperty
   a_hysteresis: assert property (p_hysteresis) else $error("thermal off released early");

   property p_dark_off;
      @(posedge i_mclk) disable iff (i_sys_rst)
         shut |=> o_high_voltage_sink_one == 8'h00 && o_lv_sink == '0 && !o_pump_en;
   endproperty
   a_dark_off: assert property (p_dark_off) else $error("sinks lit in shutdown");

   property p_enable_clears;
      @(posedge i_mclk) disable iff (i_sys_rst)
         !i_hardware_enable_pin |=> regs[OFS_SINK_CFG_ONE] == REG_RESET && zone == 3'd0;
   endproperty
   a_enable_clears: assert property (p_enable_clears) else $error("registers kept");

   property p_hv_follow;
      @(posedge i_mclk) disable iff (i_sys_rst)
         !shut |=> o_high_voltage_sink_two == $past(bank_code[regs[OFS_SINK_CFG_ONE][1]]);
   endproperty
   a_hv_follow: assert property (p_hv_follow) else $error("hv sink off its bank");

   property p_lv_follow;
      @(posedge i_mclk) disable iff (i_sys_rst)
         !shut |=> o_lv_sink[4] == $past(bank_code[N_HV_BANK + int'(regs[OFS_LV_CFG_HI][1:0])]);
   endproperty
   a_lv_follow: assert property (p_lv_follow) else $error("lv sink off its bank");

   property p_linear_plain;
      @(posedge i_mclk) disable iff (i_sys_rst)
         regs[OFS_LINEAR_SEL][0] && !regs[OFS_PWM_ASSIGN][0] &&
         regs[OFS_MAP_ASSIGN_LO][1:0] == 2'd0 |-> bank_code[0] == regs[OFS_BRIGHT_BASE];
   endproperty
   a_linear_plain: assert property (p_linear_plain) else $error("linear bank altered");

   property p_mapper_target;
      @(posedge i_mclk) disable iff (i_sys_rst)
         regs[OFS_LINEAR_SEL][1] && !regs[OFS_PWM_ASSIGN][1] &&
         regs[OFS_MAP_ASSIGN_LO][3:2] == 2'd1 && zone == 3'd0
         |-> bank_code[1] == regs[OFS_ZONE_TGT_BASE];
   endproperty
   a_mapper_target: assert property (p_mapper_target) else $error("mapper target lost");

   property p_zero_duty;
      @(posedge i_mclk) disable iff (i_sys_rst)
         regs[OFS_PWM_ASSIGN][2] && duty == 8'h00 |-> bank_code[2] <= 8'h00;
   endproperty
   a_zero_duty: assert property (p_zero_duty) else $error("pwm zero duty lit bank");

   property p_addr_ack;
      @(posedge i_mclk) disable iff (i_sys_rst || !i_hardware_enable_pin)
         bst == S_ADDR && !i_scl && scl_q && bitcnt == 4'h8 && shreg[7:1] == DEV_ADDR
         |=> o_sda_oe && bst == S_ACK;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
endmodule

/* tb/lcb_host.sv */
// two-wire host model: drives the clock and pulls the data wire low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module lcb_host (
   // clock
   input wire logic i_mclk,
   // two-wire bus
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe
);
   ////////////////////////////////////////
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   // one bus phase, held for eight clocks
   task automatic ph(input logic scl, input logic oe);
      o_scl = scl;
      o_sda_oe = oe;
      repeat (8) @(posedge i_mclk);
      #1;
   endtask
   task automatic start();
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
   endtask
   task automatic stop();
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask
   // data changes only while the clock is low
   task automatic xbit(input logic b, output logic r);
      ph(1'b0, ~b);
      ph(1'b1, ~b);
      r = i_sda;
      ph(1'b0, ~b);
   endtask
   task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(tx[i], r);
         rx[i] = r;
      end
      xbit(ack_in, ack);
   endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench of the led control bank mapper
// assumes the two-wire host model and a 250 MHz clock
`timescale 1ns/1ps
module tb_top;
   import lcb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en_pin = 1'b1;
   logic pwm = 1'b0;
   logic [7:0] ambient_light_input = 8'h00;
   logic als_v = 1'b0;
   logic hot = 1'b0;
   logic cool = 1'b1;
   logic scl, h_oe, d_sda, d_oe, sda, boost, pump;
   logic [7:0] hv1, hv2;
   logic [N_LV_SINK-1:0][7:0] lv;
   int fails = 0;
   int check_count = 0;
   int seed = 32'hcb8ed634;
   int mreg [REG_N];
   int zone = 0;
   int duty = 0;
   always #2 clk = ~clk;
   assign sda = ~(h_oe | (d_oe & ~d_sda));
   lcb_host host (.i_mclk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
   lcb_top DUT (
      .i_mclk(clk), .i_sys_rst(rst), .i_hardware_enable_pin(en_pin), .i_pwm_in(pwm),
      .i_scl(scl), .i_sda(sda), .o_sda(d_sda), .o_sda_oe(d_oe), .i_als_code(ambient_light_input),
      .i_als_valid(als_v), .i_temp_hot(hot), .i_temp_cool(cool), .o_boost_en(boost),
      .o_pump_en(pump), .o_high_voltage_sink_one(hv1), .o_high_voltage_sink_two(hv2),
      .o_lv_sink(lv)
   );
   ////////////////////////////////////////
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmp(input logic [7:0] got, input int exp);
      check_count++;
      if (got !== exp[7:0]) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp[7:0]);
      end
   endtask
   task automatic wr(input int a, input int d);
      logic k;
      logic [7:0] r;
      host.start();
      host.xbyte({DEV_ADDR, 1'b0}, 1'b1, r, k);
      host.xbyte(a[7:0], 1'b1, r, k);
      host.xbyte(d[7:0], 1'b1, r, k);
      cmp({7'h00, k}, 0);
      host.stop();
      if (a != OFS_STATUS) mreg[a] = d & 'hff;
   endtask
   task automatic rd(input int a, output logic [7:0] d);
      logic k;
      logic [7:0] r;
      host.start();
      host.xbyte({DEV_ADDR, 1'b0}, 1'b1, r, k);
      host.xbyte(a[7:0], 1'b1, r, k);
      host.stop();
      host.start();
      host.xbyte({DEV_ADDR, 1'b1}, 1'b1, r, k);
      host.xbyte(8'hff, 1'b1, d, k);
      host.stop();
   endtask
   // reference current of one bank
   function automatic int bank_val(int b);
      int c;
      int m;
      m = (b < 4) ? (mreg[OFS_MAP_ASSIGN_LO] >> (2 * b)) & 3
         : (mreg[OFS_MAP_ASSIGN_HI] >> (2 * b - 8)) & 3;
      c = (m != 0) ? mreg[OFS_ZONE_TGT_BASE + 5 * (m - 1) + zone] : mreg[OFS_BRIGHT_BASE + b];
      if (!mreg[OFS_LINEAR_SEL][b]) c = (c * c + c) >> 8;
      if (mreg[OFS_PWM_ASSIGN][b]) c = (c * duty + c) >> 8;
      return c;
   endfunction
   task automatic chk_sinks();
      int f;
      step(4);
      cmp(hv1, bank_val(mreg[OFS_SINK_CFG_ONE][0]));
      cmp(hv2, bank_val(mreg[OFS_SINK_CFG_ONE][1]));
      for (int k = 0; k < N_LV_SINK; k++) begin
         f = (k < 4) ? mreg[OFS_LV_CFG_LO] >> (2 * k) : mreg[OFS_LV_CFG_HI];
         cmp(lv[k], bank_val(2 + (f & 3)));
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      logic [7:0] v;
      logic k;
      int n;
      for (int i = 0; i < REG_N; i++) mreg[i] = 0;
      step(4);
      rst = 1'b0;
      step(2);
      rd(OFS_SINK_CFG_ONE, v);
      cmp(v, 0);
      cmp({7'h00, d_sda}, 0);
      wr(OFS_LINEAR_SEL, 'h3f);
      for (int b = 0; b < N_BANK; b++) wr(OFS_BRIGHT_BASE + b, $random(seed));
      for (int i = 0; i < 4; i++) begin
         wr(OFS_SINK_CFG_ONE, i);
         chk_sinks();
         wr(OFS_LV_CFG_LO, $random(seed));
         wr(OFS_LV_CFG_HI, i);
         chk_sinks();
      end
      wr(OFS_LINEAR_SEL, 'h2a);
      chk_sinks();
      // ambient zones: boundaries 20, 60, a0, e0
      for (int i = 0; i < 4; i++) wr(OFS_ZONE_BND_BASE + i, 'h20 + 'h40 * i);
      for (int i = 0; i < 15; i++) wr(OFS_ZONE_TGT_BASE + i, $random(seed));
      wr(OFS_MAP_ASSIGN_LO, 'hb4);
      for (int z = 0; z < N_ZONE; z++) begin
         ambient_light_input = (z == 4) ? 8'hf0 : 8'(16 + 64 * z);
         als_v = 1'b1;
         step(1);
         als_v = 1'b0;
         zone = z;
         chk_sinks();
         rd(OFS_STATUS, v);
         cmp(v, z * 2);
      end
      wr(OFS_MAP_ASSIGN_LO, 0);
      wr(OFS_STATUS, 'hff);
      rd(OFS_STATUS, v);
      cmp(v, zone * 2);
      host.start();
      host.xbyte({~DEV_ADDR, 1'b0}, 1'b1, v, k);
      host.stop();
      cmp({7'h00, k}, 1);
      wr(OFS_PWM_ASSIGN, 'h07);
      for (int p = 0; p < 2; p++) begin
         pwm = p[0];
         duty = 255 * p;
         step(6000);
         chk_sinks();
      end
      wr(OFS_PWM_ASSIGN, 0);
      hot = 1'b1;
      cool = 1'b0;
      step(4);
      cmp({boost, pump, hv1[5:0]}, 0);
      cmp(hv1 | hv2 | lv[1], 0);
      rd(OFS_STATUS, v);
      cmp(v, zone * 2 + 1);
      hot = 1'b0;
      step(8);
      cmp({6'h00, boost, pump}, 0);
      cool = 1'b1;
      step(4);
      cmp({6'h00, boost, pump}, 3);
      chk_sinks();
      en_pin = 1'b0;
      step(4);
      cmp(hv1 | hv2 | lv[0], 0);
      en_pin = 1'b1;
      for (int i = 0; i < REG_N; i++) mreg[i] = 0;
      zone = 0;
      chk_sinks();
      rd(OFS_LINEAR_SEL, v);
      cmp(v, 0);
      // two generators, each with its own levels
      wr(OFS_LINEAR_SEL, 'h3c);
      wr(OFS_LV_CFG_LO, 'h04);
      for (int g = 0; g < 2; g++) begin
         wr(OFS_PAT_BASE + PAT_STRIDE * g + PAT_RISE, g);
         wr(OFS_PAT_BASE + PAT_STRIDE * g + PAT_LOW, 3 - g);
         wr(OFS_PAT_BASE + PAT_STRIDE * g + PAT_HIGH, 8 + 4 * g);
         wr(OFS_PAT_BASE + PAT_STRIDE * g + PAT_THIGH, 'hff);
         wr(OFS_PAT_BASE + PAT_STRIDE * g + PAT_TLOW, 'hff);
      end
      wr(OFS_PAT_ENABLE, 'h03);
      for (n = 0; n < 20000 && !(lv[0] === 8'h08 && lv[1] === 8'h0c); n++) step(1);
      cmp(lv[0], 8);
      cmp(lv[1], 12);
      give_verdict();
   end
endmodule
